/* verilog/sac_defines.svh */
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SAC_ADDR_CTRL       8'h00
`define SAC_ADDR_GAIN       8'h04
`define SAC_ADDR_REF        8'h08
`define SAC_ADDR_CAL        8'h0C
`define SAC_ADDR_OC         8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SAC_CTRL_CFG        0
`define SAC_CTRL_TOGGLE     1
`define SAC_CTRL_EN_LSB     2
`define SAC_CTRL_THR        5
`define SAC_CTRL_FILT_LSB   6
`define SAC_GAIN_STRIDE     8
`define SAC_GAIN2_OFS       3
`define SAC_REF_TRIM_LSB    8
`define SAC_CAL_ABORT       3
`define SAC_CAL_ERR_LSB     4
`define SAC_CAL_BUSY        8

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define SAC_EN_RST          3'h7
`define SAC_THR_RST         1'h0
`define SAC_FILT_RST        2'h2
`define SAC_GAIN_RST        9'h000
`define SAC_REF_LOW         2'h1
`define SAC_REF_HIGH        2'h2
`define SAC_TRIM_RST        6'h1F

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SAC_CLK_MHZ         250
`define SAC_FILT0_NS        1500
`define SAC_FILT1_NS        3000
`define SAC_FILT2_NS        5000
`define SAC_FILT3_NS        10000
`define SAC_FILT0_CYC       ((`SAC_FILT0_NS * `SAC_CLK_MHZ) / 1000)
`define SAC_FILT1_CYC       ((`SAC_FILT1_NS * `SAC_CLK_MHZ) / 1000)
`define SAC_FILT2_CYC       ((`SAC_FILT2_NS * `SAC_CLK_MHZ) / 1000)
`define SAC_FILT3_CYC       ((`SAC_FILT3_NS * `SAC_CLK_MHZ) / 1000)
`define SAC_CAL_TIME_US     100
`define SAC_CAL_MAX_CYC     (`SAC_CAL_TIME_US * `SAC_CLK_MHZ)

`endif

/* verilog/sac_pkg.sv */
`default_nettype none

package sac_pkg;

	typedef enum logic [0:0] {
		SAC_CAL_IDLE = 1'b0,
		SAC_CAL_RUN  = 1'b1
	} sac_cal_state_t;

	typedef logic [11:0] sac_filt_cnt_t;
	typedef logic [15:0] sac_cal_cnt_t;

	// lowest selected amplifier wins
	function automatic logic [2:0] sac_first(input logic [2:0] m);
		logic [2:0] r;
		r = 3'h0;
		if (m[0]) begin
			r = 3'h1;
		end else if (m[1]) begin
			r = 3'h2;
		end else if (m[2]) begin
			r = 3'h4;
		end
		return r;
	endfunction

endpackage

`default_nettype wire

/* verilog/sac_oc_filter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"

module sac_oc_filter
	import sac_pkg::*;
	(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       above,
	input  wire logic [1:0] filtSel,
	output logic            trip
	);

	sac_filt_cnt_t cnt;
	sac_filt_cnt_t next_cnt;
	sac_filt_cnt_t limit;
	logic          next_trip;

	always_comb begin
		case (filtSel)
			2'h0:    limit = sac_filt_cnt_t'(`SAC_FILT0_CYC);
			2'h1:    limit = sac_filt_cnt_t'(`SAC_FILT1_CYC);
			2'h2:    limit = sac_filt_cnt_t'(`SAC_FILT2_CYC);
			default: limit = sac_filt_cnt_t'(`SAC_FILT3_CYC);
		endcase
		next_cnt  = cnt;
		next_trip = 1'b0;
		if (!above) begin
			next_cnt = '0;
		end else if (cnt <= limit) begin
			next_cnt = cnt + 12'h001;
		end
		// one pulse once the level has held past the filter time
		if (above && cnt == limit) begin
			next_trip = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt  <= '0;
			trip <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			trip <= next_trip;
		end
	end

	filt_restart_a: assert property (@(posedge clk) disable iff (reset)
		!above |=> cnt == 12'h000)
		else $error("filter count not restarted");
	filt_trip_a: assert property (@(posedge clk) disable iff (reset)
		trip |-> $past(above) && $past(cnt) == $past(limit))
		else $error("overcurrent reported too early");

endmodule
`default_nettype wire

/* verilog/sac_cal_seq.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"

module sac_cal_seq
	import sac_pkg::*;
	#(parameter int CAL_MAX_CYC = `SAC_CAL_MAX_CYC)
	(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [2:0]  start,
	input  wire logic        abort,
	input  wire logic        calAck,
	input  wire logic        calFail,
	input  wire logic [5:0]  calCode,
	output logic      [2:0]  calActive,
	output logic      [2:0]  calErr,
	output logic      [17:0] ampOffset
	);

	sac_cal_state_t state;
	sac_cal_state_t next_state;
	logic [2:0]     pending;
	logic [2:0]     next_pending;
	logic [2:0]     next_calActive;
	logic [2:0]     next_calErr;
	logic [17:0]    next_ampOffset;
	sac_cal_cnt_t   timer;
	sac_cal_cnt_t   next_timer;

	always_comb begin
		next_state     = state;
		next_pending   = pending | start;
		next_calActive = calActive;
		next_calErr    = 3'h0;
		next_ampOffset = ampOffset;
		next_timer     = timer;
		case (state)
			SAC_CAL_IDLE: begin
				if (abort) begin
					next_pending = 3'h0;
				end else if (pending != 3'h0) begin
					next_calActive = sac_first(pending);
					next_timer     = '0;
					next_state     = SAC_CAL_RUN;
				end
			end
			SAC_CAL_RUN: begin
				next_timer = timer + 16'h0001;
				if (abort) begin
					// stored offsets stay as they were
					next_pending   = 3'h0;
					next_calActive = 3'h0;
					next_state     = SAC_CAL_IDLE;
				end else if (calAck || timer == sac_cal_cnt_t'(CAL_MAX_CYC - 1)) begin
					if (calAck && !calFail) begin
						for (int i = 0; i < 3; i++) begin
							if (calActive[i]) begin
								next_ampOffset[6*i +: 6] = calCode;
							end
						end
					end else begin
						next_calErr = calActive;
					end
					next_pending   = (pending & ~calActive) | start;
					next_calActive = 3'h0;
					next_state     = SAC_CAL_IDLE;
				end
			end
			default: begin
				next_state     = SAC_CAL_IDLE;
				next_calActive = 3'h0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state     <= SAC_CAL_IDLE;
			pending   <= 3'h0;
			calActive <= 3'h0;
			calErr    <= 3'h0;
			ampOffset <= 18'h0_0000;
			timer     <= '0;
		end else begin
			state     <= next_state;
			pending   <= next_pending;
			calActive <= next_calActive;
			calErr    <= next_calErr;
			ampOffset <= next_ampOffset;
			timer     <= next_timer;
		end
	end

	cal_order_a: assert property (@(posedge clk) disable iff (reset)
		$rose(calActive[1]) |-> !$past(pending[0]))
		else $error("amplifier 2 calibrated before amplifier 1");
	cal_bound_a: assert property (@(posedge clk) disable iff (reset)
		calActive != 3'h0 |-> timer < sac_cal_cnt_t'(CAL_MAX_CYC))
		else $error("calibration exceeded its longest time");
	cal_fail_a: assert property (@(posedge clk) disable iff (reset)
		state == SAC_CAL_RUN && calAck && calFail && !abort
		|=> calErr == $past(calActive) && $stable(ampOffset))
		else $error("failed calibration not flagged or offset changed");
	cal_abort_a: assert property (@(posedge clk) disable iff (reset)
		abort |=> calActive == 3'h0 && $stable(ampOffset))
		else $error("abort did not stop calibration");

endmodule
`default_nettype wire

/* verilog/sac_shunt_amp_control.sv */
// Contract
// - three-bit gain code, 000 lowest, 111 highest
// - two gain fields per amplifier, either active
// - gains writable at run time, no recalibration
// - two-bit reference level, 01 default, 00/11 reserved
// - six-bit reference trim, default 0x1F
// - calibration started per amplifier over serial
// - each amplifier calibrates within bounded time
// - calibrate amplifier 1, then 2, then 3
// - failed calibration sets readable error flag
// - abort or failure keeps last valid offset
// - no calibration in configuration mode
// - overcurrent only after exceeding filter time
// - one-bit threshold select, default 0 (5 V)
// - filter select 1.5/3/5/10 us, default 5 us
// - shared overcurrent settings for all amplifiers
// - amplifiers disabled in configuration; keep amplifier 1 (its enable bit can still be written to 0)
// - amplifier 3 may give one spurious overcurrent
// - toggle bit swaps all gains, reads active
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"

module sac_shunt_amp_control
	import sac_pkg::*;
	#(parameter int CAL_MAX_CYC = `SAC_CAL_MAX_CYC)
	(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  ocAbove,
	input  wire logic        calAck,
	input  wire logic        calFail,
	input  wire logic [5:0]  calCode,
	output logic      [8:0]  ampGain,
	output logic      [1:0]  refLevel,
	output logic      [5:0]  refTrim,
	output logic      [2:0]  ampEnable,
	output logic             ocThresholdSel,
	output logic             cfgMode,
	output logic      [2:0]  calActive,
	output logic      [17:0] ampOffset,
	output logic      [2:0]  ocFlag
	);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic        gainToggle;
	logic [1:0]  ocFilterSel;
	logic [8:0]  gain1;
	logic [8:0]  gain2;
	logic [2:0]  calErrFlag;
	logic        next_cfgMode;
	logic        next_gainToggle;
	logic [2:0]  next_ampEnable;
	logic        next_ocThresholdSel;
	logic [1:0]  next_ocFilterSel;
	logic [8:0]  next_gain1;
	logic [8:0]  next_gain2;
	logic [8:0]  next_ampGain;
	logic [1:0]  next_refLevel;
	logic [5:0]  next_refTrim;
	logic [2:0]  next_calErrFlag;
	logic [2:0]  next_ocFlag;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic [2:0]  calStart;
	logic        calAbortReq;
	logic [2:0]  calErr;
	logic [2:0]  ocTrip;
	logic [2:0]  ocLevel;
	logic        wrAccess;
	logic        rdSetup;

	assign wrAccess = psel && penable && pready && pwrite;
	assign rdSetup  = psel && penable && !pready;

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	always_comb begin
		next_cfgMode        = cfgMode;
		next_gainToggle     = gainToggle;
		next_ampEnable      = ampEnable;
		next_ocThresholdSel = ocThresholdSel;
		next_ocFilterSel    = ocFilterSel;
		next_gain1          = gain1;
		next_gain2          = gain2;
		next_refLevel       = refLevel;
		next_refTrim        = refTrim;
		next_calErrFlag     = calErrFlag | calErr;
		next_ocFlag         = ocFlag | ocTrip;
		calStart            = 3'h0;
		calAbortReq         = 1'b0;
		if (wrAccess) begin
			case (paddr)
				`SAC_ADDR_CTRL: begin
					next_cfgMode     = pwdata[`SAC_CTRL_CFG];
					next_gainToggle  = pwdata[`SAC_CTRL_TOGGLE];
					// enables only change while configuring
					if (cfgMode) begin
						next_ampEnable = pwdata[`SAC_CTRL_EN_LSB +: 3];
					end
					next_ocThresholdSel = pwdata[`SAC_CTRL_THR];
					next_ocFilterSel = pwdata[`SAC_CTRL_FILT_LSB +: 2];
				end
				`SAC_ADDR_GAIN: begin
					for (int i = 0; i < 3; i++) begin
						next_gain1[3*i +: 3] =
							pwdata[`SAC_GAIN_STRIDE*i +: 3];
						next_gain2[3*i +: 3] =
							pwdata[`SAC_GAIN_STRIDE*i + `SAC_GAIN2_OFS +: 3];
					end
				end
				`SAC_ADDR_REF: begin
					// reserved level codes leave the level unchanged
					if (pwdata[1:0] == `SAC_REF_LOW ||
					    pwdata[1:0] == `SAC_REF_HIGH) begin
						next_refLevel = pwdata[1:0];
					end
					next_refTrim = pwdata[`SAC_REF_TRIM_LSB +: 6];
				end
				`SAC_ADDR_CAL: begin
					calStart = pwdata[2:0] & ampEnable & {3{~cfgMode}};
					calAbortReq = pwdata[`SAC_CAL_ABORT];
					next_calErrFlag = (calErrFlag &
						~pwdata[`SAC_CAL_ERR_LSB +: 3]) | calErr;
				end
				`SAC_ADDR_OC: begin
					next_ocFlag = (ocFlag & ~pwdata[2:0]) | ocTrip;
				end
				default: begin
				end
			endcase
		end
		for (int i = 0; i < 3; i++) begin
			next_ampGain[3*i +: 3] = gainToggle ? gain2[3*i +: 3] :
				gain1[3*i +: 3];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cfgMode        <= 1'b1;
			gainToggle     <= 1'b0;
			ampEnable      <= `SAC_EN_RST;
			ocThresholdSel <= `SAC_THR_RST;
			ocFilterSel    <= `SAC_FILT_RST;
			gain1          <= `SAC_GAIN_RST;
			gain2          <= `SAC_GAIN_RST;
			ampGain        <= `SAC_GAIN_RST;
			refLevel       <= `SAC_REF_LOW;
			refTrim        <= `SAC_TRIM_RST;
			calErrFlag     <= 3'h0;
			ocFlag         <= 3'h0;
		end else begin
			cfgMode        <= next_cfgMode;
			gainToggle     <= next_gainToggle;
			ampEnable      <= next_ampEnable;
			ocThresholdSel <= next_ocThresholdSel;
			ocFilterSel    <= next_ocFilterSel;
			gain1          <= next_gain1;
			gain2          <= next_gain2;
			ampGain        <= next_ampGain;
			refLevel       <= next_refLevel;
			refTrim        <= next_refTrim;
			calErrFlag     <= next_calErrFlag;
			ocFlag         <= next_ocFlag;
		end
	end

	// ------------------------------------------------------------------
	// apb response, one wait state
	// ------------------------------------------------------------------
	always_comb begin
		next_pready  = rdSetup;
		next_pslverr = 1'b0;
		next_prdata  = 32'h0000_0000;
		if (rdSetup) begin
			case (paddr)
				`SAC_ADDR_CTRL: begin
					next_prdata[`SAC_CTRL_CFG]          = cfgMode;
					next_prdata[`SAC_CTRL_TOGGLE]       = gainToggle;
					next_prdata[`SAC_CTRL_EN_LSB +: 3]  = ampEnable;
					next_prdata[`SAC_CTRL_THR]          = ocThresholdSel;
					next_prdata[`SAC_CTRL_FILT_LSB +: 2] = ocFilterSel;
				end
				`SAC_ADDR_GAIN: begin
					for (int i = 0; i < 3; i++) begin
						next_prdata[`SAC_GAIN_STRIDE*i +: 3] = gain1[3*i +: 3];
						next_prdata[`SAC_GAIN_STRIDE*i + `SAC_GAIN2_OFS +: 3] =
							gain2[3*i +: 3];
					end
				end
				`SAC_ADDR_REF: begin
					next_prdata[1:0]                    = refLevel;
					next_prdata[`SAC_REF_TRIM_LSB +: 6] = refTrim;
				end
				`SAC_ADDR_CAL: begin
					next_prdata[2:0]                    = calActive;
					next_prdata[`SAC_CAL_ERR_LSB +: 3]  = calErrFlag;
					next_prdata[`SAC_CAL_BUSY]          = calActive != 3'h0;
				end
				`SAC_ADDR_OC: begin
					next_prdata[2:0] = ocFlag;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// ------------------------------------------------------------------
	// calibration and overcurrent
	// ------------------------------------------------------------------
	sac_cal_seq #(.CAL_MAX_CYC(CAL_MAX_CYC)) calSeq (
		.clk       (clk),
		.reset     (reset),
		.start     (calStart),
		.abort     (calAbortReq || cfgMode),
		.calAck    (calAck),
		.calFail   (calFail),
		.calCode   (calCode),
		.calActive (calActive),
		.calErr    (calErr),
		.ampOffset (ampOffset)
	);

	// disabled amplifiers and configuration mode never trip
	assign ocLevel = ocAbove & ampEnable & {3{~cfgMode}};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gOcFilt
			sac_oc_filter ocFilt (
				.clk     (clk),
				.reset   (reset),
				.above   (ocLevel[g]),
				.filtSel (ocFilterSel),
				.trip    (ocTrip[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	ref_reset_a: assert property (@(posedge clk) disable iff (reset)
		$fell(reset) |-> refLevel == `SAC_REF_LOW && refTrim == `SAC_TRIM_RST)
		else $error("reference reset values wrong");
	ref_legal_a: assert property (@(posedge clk) disable iff (reset)
		refLevel == `SAC_REF_LOW || refLevel == `SAC_REF_HIGH)
		else $error("reserved reference level active");
	cfg_block_a: assert property (@(posedge clk) disable iff (reset)
		cfgMode |=> calActive == 3'h0)
		else $error("calibration running in configuration mode");
	gain_swap_a: assert property (@(posedge clk) disable iff (reset)
		wrAccess && paddr == `SAC_ADDR_CTRL && pwdata[`SAC_CTRL_TOGGLE]
		|=> ##1 ampGain[8:6] == gain2[8:6])
		else $error("gain toggle did not select second gain");
	oc_sticky_a: assert property (@(posedge clk) disable iff (reset)
		ocTrip[2] |=> ocFlag[2])
		else $error("overcurrent event lost");
	apb_wait_a: assert property (@(posedge clk) disable iff (reset)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
	en_lock_a: assert property (@(posedge clk) disable iff (reset)
		!$past(cfgMode) |-> $stable(ampEnable))
		else $error("enables changed outside configuration");
	cal_onehot_a: assert property (@(posedge clk) disable iff (reset)
		$onehot0(calActive))
		else $error("more than one amplifier calibrating");
	gain_live_a: assert property (@(posedge clk) disable iff (reset)
		!gainToggle |=> ampGain == $past(gain1))
		else $error("first gain register not applied");

endmodule
`default_nettype wire

/* verif/sac_shunt_partner.sv */
`timescale 1ns/1ns
`default_nettype none

module sac_shunt_partner (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [2:0] calActive,
	input  wire logic [2:0] ampEnable,
	input  wire logic [2:0] overDrive,
	input  wire logic [5:0] calMode,
	input  wire logic [7:0] calDelay,
	output logic            calAck,
	output logic            calFail,
	output logic      [5:0] calCode,
	output logic      [2:0] ocAbove
	);

	logic [7:0] count;
	logic [2:0] lastActive;
	logic [6:0] noise;
	logic [1:0] mode;

	// ------------------------------------------------------------------
	// analog calibration answer, per amplifier: pass, fail or silent
	// ------------------------------------------------------------------
	always_comb begin
		mode = calActive[0] ? calMode[1:0]
			: (calActive[1] ? calMode[3:2] : calMode[5:4]);
		calAck  = (calActive != 3'h0) && (count == calDelay)
			&& (mode != 2'h2);
		// result lines only mean something with the acknowledge
		calFail = calAck ? (mode == 2'h1) : noise[0];
		calCode = calAck ? (6'h2A ^ {3'h0, calActive}) : noise[6:1];
	end

	always_ff @(posedge clk) begin
		lastActive <= calActive;
		if (reset) begin
			noise <= 7'h00;
		end else begin
			noise <= noise + 7'h25;
		end
		if (reset || calActive == 3'h0 || calActive != lastActive) begin
			count <= 8'h00;
		end else if (count != 8'hFF) begin
			count <= count + 8'h01;
		end
	end

	// unused amplifier is switched off and sits at the reference
	assign ocAbove = overDrive & ampEnable;

endmodule

`default_nettype wire

/* verif/sac_shunt_amp_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sac_defines.svh"

module sac_shunt_amp_control_tb;

	logic        clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        pready;
	logic        pslverr;
	logic        calAck;
	logic        calFail;
	logic        ocThresholdSel;
	logic        cfgMode;
	logic [7:0]  paddr;
	logic [7:0]  calDelay;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [2:0]  ocAbove;
	logic [2:0]  overDrive;
	logic [2:0]  ampEnable;
	logic [2:0]  calActive;
	logic [2:0]  ocFlag;
	logic [5:0]  calCode;
	logic [5:0]  calMode;
	logic [5:0]  refTrim;
	logic [8:0]  ampGain;
	logic [1:0]  refLevel;
	logic [17:0] ampOffset;
	int          miscompares;
	int          checked;

	sac_shunt_amp_control #(.CAL_MAX_CYC(50)) DUT (
		.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ocAbove(ocAbove), .calAck(calAck), .calFail(calFail),
		.calCode(calCode), .ampGain(ampGain), .refLevel(refLevel),
		.refTrim(refTrim), .ampEnable(ampEnable),
		.ocThresholdSel(ocThresholdSel), .cfgMode(cfgMode),
		.calActive(calActive), .ampOffset(ampOffset), .ocFlag(ocFlag)
	);

	sac_shunt_partner farSide (
		.clk(clk), .reset(reset), .calActive(calActive),
		.ampEnable(ampEnable), .overDrive(overDrive), .calMode(calMode),
		.calDelay(calDelay), .calAck(calAck), .calFail(calFail),
		.calCode(calCode), .ocAbove(ocAbove)
	);

	initial clk = 1'b0;
	always #2 clk = ~clk;

	// ------------------------------------------------------------------
	// bus cycles and comparisons
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// a missing answer is caught by the watchdog
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic err);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0000_0000, r, e);
		chk(r, exp);
		chk({31'h0, e}, {31'h0, err});
	endtask

	task automatic waitAct(input logic [2:0] exp, input int limit);
		int n;
		n = 0;
		while (calActive !== exp && n < limit) begin
			@(posedge clk);
			n++;
		end
		chk(32'(calActive), 32'(exp));
	endtask

	task automatic end_of_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		end_of_test();
	end

	// ------------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------------
	initial begin
		int lim [4];
		lim = '{`SAC_FILT0_CYC, `SAC_FILT1_CYC, `SAC_FILT2_CYC, `SAC_FILT3_CYC};
		miscompares = 0;
		checked = 0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		overDrive = 3'h0;
		calMode = 6'h00;
		calDelay = 8'h0A;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd(`SAC_ADDR_CTRL, 32'h0000_009D, 1'b0);
		rd(`SAC_ADDR_REF, 32'h0000_1F01, 1'b0);
		rd(`SAC_ADDR_CAL, 32'h0000_0000, 1'b0);
		rd(8'h14, 32'h0000_0000, 1'b1);
		wr(`SAC_ADDR_REF, 32'h0000_3F02);
		rd(`SAC_ADDR_REF, 32'h0000_3F02, 1'b0);
		wr(`SAC_ADDR_REF, 32'h0000_0000);
		rd(`SAC_ADDR_REF, 32'h0000_0002, 1'b0);
		wr(`SAC_ADDR_REF, 32'h0000_0003);
		rd(`SAC_ADDR_REF, 32'h0000_0002, 1'b0);
		chk(32'(refLevel), 32'h0000_0002);
		chk(32'(refTrim), 32'h0000_0000);
		wr(`SAC_ADDR_GAIN, 32'h0015_0738);
		rd(`SAC_ADDR_GAIN, 32'h0015_0738, 1'b0);
		chk(32'(ampGain), 32'h0000_0178);
		wr(`SAC_ADDR_CTRL, 32'h0000_009F);
		rd(`SAC_ADDR_CTRL, 32'h0000_009F, 1'b0);
		chk(32'(ampGain), 32'h0000_0087);
		wr(`SAC_ADDR_CTRL, 32'h0000_0085);
		repeat (2) @(posedge clk);
		chk(32'(ampEnable), 32'h0000_0001);
		wr(`SAC_ADDR_CAL, 32'h0000_0007);
		repeat (5) @(posedge clk);
		chk(32'(calActive), 32'h0000_0000);
		// amplifier 1 stays on with the others; gain one active
		wr(`SAC_ADDR_CTRL, 32'h0000_009D);
		wr(`SAC_ADDR_CTRL, 32'h0000_003C);
		wr(`SAC_ADDR_CTRL, 32'h0000_0020);
		rd(`SAC_ADDR_CTRL, 32'h0000_003C, 1'b0);
		chk(32'(cfgMode), 32'h0000_0000);
		chk(32'(ocThresholdSel), 32'h0000_0001);
		chk(32'(ampEnable), 32'h0000_0007);
		rd(`SAC_ADDR_OC, 32'h0000_0000, 1'b0);
		// amp 1 passes, amp 2 fails, amp 3 never answers
		calMode <= 6'h24;
		wr(`SAC_ADDR_CAL, 32'h0000_0007);
		waitAct(3'h1, 10);
		waitAct(3'h2, 40);
		waitAct(3'h4, 40);
		waitAct(3'h0, 60);
		repeat (4) @(posedge clk);
		chk(32'(ampOffset), 32'h0000_002B);
		rd(`SAC_ADDR_CAL, 32'h0000_0060, 1'b0);
		wr(`SAC_ADDR_CAL, 32'h0000_0070);
		rd(`SAC_ADDR_CAL, 32'h0000_0000, 1'b0);
		wr(`SAC_ADDR_GAIN, 32'h0007_0000);
		repeat (3) @(posedge clk);
		chk(32'(ampGain), 32'h0000_01C0);
		chk(32'(ampOffset), 32'h0000_002B);
		calMode <= 6'h00;
		calDelay <= 8'hC8;
		wr(`SAC_ADDR_CAL, 32'h0000_0001);
		waitAct(3'h1, 10);
		wr(`SAC_ADDR_CAL, 32'h0000_0008);
		repeat (2) @(posedge clk);
		chk(32'(calActive), 32'h0000_0000);
		chk(32'(ampOffset), 32'h0000_002B);
		for (int k = 0; k < 4; k++) begin
			wr(`SAC_ADDR_CTRL, 32'h0000_003C | (32'(k) << 6));
			overDrive <= 3'h7;
			repeat (lim[k] - 5) @(posedge clk);
			chk(32'(ocFlag), 32'h0000_0000);
			repeat (10) @(posedge clk);
			chk(32'(ocFlag), 32'h0000_0007);
			overDrive <= 3'h0;
			wr(`SAC_ADDR_OC, 32'h0000_0007);
			rd(`SAC_ADDR_OC, 32'h0000_0000, 1'b0);
		end
		wr(`SAC_ADDR_CTRL, 32'h0000_003C);
		overDrive <= 3'h1;
		repeat (lim[0] - 10) @(posedge clk);
		overDrive <= 3'h0;
		repeat (2) @(posedge clk);
		overDrive <= 3'h1;
		repeat (lim[0] - 10) @(posedge clk);
		chk(32'(ocFlag), 32'h0000_0000);
		repeat (20) @(posedge clk);
		chk(32'(ocFlag), 32'h0000_0001);
		end_of_test();
	end

endmodule

`default_nettype wire
